/* rtl/pcel_event_latches.sv */
// Purpose: Sticky per-channel event registers behind the command port
// Assumes: All inputs come from logic on clk; no synchronisers needed
// Notes:   Reads answer one cycle after the request; set beats clear
//          A clearing read and a new event in one cycle keep the event
//          4-pair merging holds early halves in a small wait flag
//          No long timers here; merged bits release at once
//          Overload and limit timers live outside this block
`timescale 1ns/1ps

// One sticky register: a set always beats a clear in the same cycle
module pcel_latch8 (
   input  wire logic                       clk,      // System clock
   input  wire logic                       sys_rst,  // Sync reset
   input  wire logic [pcel_pkg::REG_W-1:0] setBits,  // Event pulses
   input  wire logic [pcel_pkg::REG_W-1:0] clrBits,  // Clear requests
   output logic      [pcel_pkg::REG_W-1:0] q         // Latched events
);
   import pcel_pkg::*;

   logic [REG_W-1:0] bits_q;  // Stored events
   logic [REG_W-1:0] bits_d;  // Next stored events

   // New events stay latched past a clear
   assign bits_d = setBits | (bits_q & ~clrBits);
   assign q      = bits_q;

   // Storage; the reset value is the empty register
   // Every bit is written on every edge, no enable
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bits_q <= EVENT_RESET;
      end else begin
         bits_q <= bits_d;
      end
   end
endmodule

// Event latch bank for four channels
module pcel_event_latches (
   input  wire logic                          clk,
   input  wire logic                          sys_rst,
   // Command port from the serial interface engine
   input  wire logic                          rdReq,
   input  wire logic [7:0]                    rdCode,
   output logic      [7:0]                    rdData,
   output logic                               rdAck,
   output logic                               rdMiss,
   // Port configuration
   input  wire pcel_pkg::pcel_mode_t          opMode,
   input  wire logic [1:0]                    fourPair,
   input  wire logic [1:0]                    dualSig,
   input  wire logic                          classChangeOnly,
   input  wire logic                          detectChangeOnly,
   input  wire logic [7:0]                    irqMask,
   // Per-channel status; events are one-cycle pulses
   // Switching a channel off empties its bits in three banks
   input  wire logic [pcel_pkg::NUM_CHAN-1:0] chanOff,
   input  wire logic [pcel_pkg::NUM_CHAN-1:0] powerOnPending,
   input  wire logic [pcel_pkg::NUM_CHAN-1:0] detectDone,
   input  wire logic [pcel_pkg::NUM_CHAN-1:0] detectChanged,
   input  wire logic [pcel_pkg::NUM_CHAN-1:0] classDone,
   input  wire logic [pcel_pkg::NUM_CHAN-1:0] classChanged,
   input  wire logic [pcel_pkg::NUM_CHAN-1:0] disconnectSeen,
   input  wire logic [pcel_pkg::NUM_CHAN-1:0] overloadTimeout,
   input  wire logic [pcel_pkg::NUM_CHAN-1:0] overloadShutdownOff,
   input  wire logic [pcel_pkg::NUM_CHAN-1:0] currentHoldTimeout,
   input  wire logic [pcel_pkg::NUM_CHAN-1:0] inrushTimeout,
   input  wire logic [pcel_pkg::NUM_CHAN-1:0] discoveryInvalid,
   input  wire logic [pcel_pkg::NUM_CHAN-1:0] powerEnableChange,
   // Re-power request for one half of a dual-signature port
   input  wire logic [pcel_pkg::NUM_CHAN-1:0] powerOnRequest,
   input  wire logic [pcel_pkg::NUM_CHAN-1:0] discoveryValid,
   input  wire logic [pcel_pkg::NUM_CHAN-1:0] allocationOk,
   output logic      [pcel_pkg::NUM_CHAN-1:0] powerOnGrant,
   output logic      [pcel_pkg::NUM_CHAN-1:0] overloadShutdown,
   // Interrupt side
   output logic      [7:0]                    irqSummary,
   output logic                               int_n
);
   import pcel_pkg::*;

   // Channel-wide views of the per-port settings
   logic [NUM_CHAN-1:0] fourPairCh;     // Channel is half of a 4-pair port
   logic [NUM_CHAN-1:0] dualCh;         // 4-pair port, dual signature
   logic [NUM_CHAN-1:0] singleCh;       // 4-pair port, single signature
   logic [NUM_CHAN-1:0] pendPairCh;     // Power request pending on port
   logic                isAuto;         // Auto mode
   logic                isSemi;         // Semi-auto mode

   // Discovery event shaping
   logic [NUM_CHAN-1:0] indepCh;        // Bits set per channel
   logic [NUM_CHAN-1:0] detMergeCh;     // Detect bits wait for partner
   logic [NUM_CHAN-1:0] clsMergeCh;     // Class bits wait for partner

   // Qualified events after the change-only settings
   logic [NUM_CHAN-1:0] detEvent;       // Qualified detect event
   logic [NUM_CHAN-1:0] clsEvent;       // Qualified class event

   // Partner wait bookkeeping
   logic [NUM_CHAN-1:0] detHave;        // Detect ready this channel
   logic [NUM_CHAN-1:0] clsHave;        // Class ready this channel
   logic [NUM_CHAN-1:0] detRelease;     // Both halves ready
   logic [NUM_CHAN-1:0] clsRelease;     // Both halves ready

   // Bits handed to the detect/class register
   logic [NUM_CHAN-1:0] detSet;         // Detect bits to set
   logic [NUM_CHAN-1:0] clsSet;         // Class bits to set

   // Wait flags, cleared when the channel goes off
   logic [NUM_CHAN-1:0] detPend_q;      // Detect waiting for partner
   logic [NUM_CHAN-1:0] detPend_d;
   logic [NUM_CHAN-1:0] clsPend_q;      // Class waiting for partner
   logic [NUM_CHAN-1:0] clsPend_d;

   // Fault shaping
   logic [NUM_CHAN-1:0] discSet;        // Disconnect bits to set
   logic [NUM_CHAN-1:0] startSet;       // Start fault bits to set

   // Register set and clear vectors
   logic [REG_W-1:0]    offMask;        // Bits of channels switched off

   // Set vectors, one per register
   logic [REG_W-1:0]    detBankSet;     // Detect/class sets
   logic [REG_W-1:0]    fltBankSet;     // Disconnect/overload sets
   logic [REG_W-1:0]    stlBankSet;     // Start/limit sets
   logic [REG_W-1:0]    pecBankSet;     // Enable change sets

   // Clear vectors, one per register
   logic [REG_W-1:0]    detBankClr;     // Detect/class clears
   logic [REG_W-1:0]    fltBankClr;     // Disconnect/overload clears
   logic [REG_W-1:0]    stlBankClr;     // Start/limit clears
   logic [REG_W-1:0]    pecBankClr;     // Enable change clears

   // Register contents as stored
   logic [REG_W-1:0]    detBank;        // Detect/class register
   logic [REG_W-1:0]    fltBank;        // Disconnect/overload register
   logic [REG_W-1:0]    stlBank;        // Start/limit register
   logic [REG_W-1:0]    pecBank;        // Power enable change register

   // Command decode
   logic                hitDet;         // Code names detect/class bank
   logic                hitFlt;         // Code names fault bank
   logic                hitStl;         // Code names start/limit bank
   logic                hitPec;         // Code names enable change bank
   logic                hitAny;         // Code is mapped

   // Clearing read strobes, qualified by the request
   logic                clrDet;         // Clearing read of each bank
   logic                clrFlt;
   logic                clrStl;
   logic                clrPec;
   logic [7:0]          rdSel;          // Selected read data

   // Outputs and their next values
   // Read answer: byte, acknowledge, miss
   logic [7:0]          rdData_q;
   logic [7:0]          rdData_d;
   logic                rdAck_q;
   logic                rdMiss_q;

   // Interrupt side
   logic [7:0]          irqSummary_q;
   logic [7:0]          irqSummary_d;
   logic                intN_q;
   logic                intN_d;

   // Channel control
   logic [NUM_CHAN-1:0] powerOnGrant_q;
   logic [NUM_CHAN-1:0] powerOnGrant_d;
   logic [NUM_CHAN-1:0] ovlShut_q;
   logic [NUM_CHAN-1:0] ovlShut_d;

   // Swap each channel with its 4-pair partner
   // Channel 1 pairs with 2 and channel 3 with 4
   // Used for the pending request, for waiting and for spreading a disconnect
   function automatic logic [NUM_CHAN-1:0] partner(
      input logic [NUM_CHAN-1:0] v
   );
      partner = {v[2], v[3], v[0], v[1]};
   endfunction

   // Port settings spread per channel
   assign fourPairCh = {{2{fourPair[1]}}, {2{fourPair[0]}}};
   assign dualCh     = fourPairCh & {{2{dualSig[1]}}, {2{dualSig[0]}}};
   assign singleCh   = fourPairCh & ~dualCh;
   assign pendPairCh = powerOnPending | partner(powerOnPending);
   assign isAuto     = (opMode == MODE_AUTO);
   assign isSemi     = (opMode == MODE_SEMI);

   // Which channels report on their own
   // Plain 2-pair channels, a pending request or dual auto mode
   assign indepCh    = ~fourPairCh | pendPairCh
                     | (dualCh & {NUM_CHAN{isAuto}});
   assign detMergeCh = ~indepCh;
   // Only dual semi-auto discovery merges class bits
   assign clsMergeCh = ~indepCh & dualCh & {NUM_CHAN{isSemi}};

   // Any cycle, or only a change of result
   assign detEvent = detectDone
                   & (~{NUM_CHAN{detectChangeOnly}} | detectChanged);
   assign clsEvent = classDone
                   & (~{NUM_CHAN{classChangeOnly}} | classChanged);

   // Partner wait: release both halves in the same cycle
   assign detHave    = detEvent | detPend_q;
   assign clsHave    = clsEvent | clsPend_q;
   assign detRelease = detHave & partner(detHave) & detMergeCh;
   assign clsRelease = clsHave & partner(clsHave) & clsMergeCh;
   // Single signature: class bit only where classified
   assign detSet = (detEvent & ~detMergeCh) | detRelease;
   assign clsSet = (clsEvent & ~clsMergeCh) | clsRelease;
   assign detPend_d = detHave & detMergeCh & ~detRelease & ~chanOff;
   assign clsPend_d = clsHave & clsMergeCh & ~clsRelease & ~chanOff;

   // Disconnect spreads to both halves of a single signature port
   // Dual signature halves keep their own disconnects
   assign discSet = disconnectSeen
                  | (partner(disconnectSeen) & singleCh);
   // Auto mode hides start faults from invalid discovery
   assign startSet = inrushTimeout
                   & ~({NUM_CHAN{isAuto}} & discoveryInvalid);

   // Bank set vectors; merged or spread 4-pair halves update together
   // Upper nibble first, lower nibble second
   assign detBankSet = {clsSet, detSet};
   assign fltBankSet = {discSet, overloadTimeout};
   assign stlBankSet = {currentHoldTimeout, startSet};
   assign pecBankSet = {{NUM_CHAN{1'b0}}, powerEnableChange};

   // Command decode
   assign hitDet = (rdCode == CMD_DET_EV) | (rdCode == CMD_DET_EV_CR);
   assign hitFlt = (rdCode == CMD_FLT_EV) | (rdCode == CMD_FLT_EV_CR);
   assign hitStl = (rdCode == CMD_STL_EV) | (rdCode == CMD_STL_EV_CR);
   assign hitPec = (rdCode == CMD_PWR_EV) | (rdCode == CMD_PWR_EV_CR);
   assign hitAny = hitDet | hitFlt | hitStl | hitPec;
   assign clrDet = rdReq & (rdCode == CMD_DET_EV_CR);
   assign clrFlt = rdReq & (rdCode == CMD_FLT_EV_CR);
   assign clrStl = rdReq & (rdCode == CMD_STL_EV_CR);
   assign clrPec = rdReq & (rdCode == CMD_PWR_EV_CR);

   // Clears: switched-off channel or clearing read
   // The enable change bank is not emptied by a channel going off
   assign offMask    = {chanOff, chanOff};
   assign detBankClr = offMask | {REG_W{clrDet}};
   // Overload timers live elsewhere and see no clear
   assign fltBankClr = offMask | {REG_W{clrFlt}};
   assign stlBankClr = offMask | {REG_W{clrStl}};
   assign pecBankClr = {REG_W{clrPec}};

   // Both codes of a bank return the same contents
   assign rdSel = hitDet ? detBank
                : hitFlt ? fltBank
                : hitStl ? stlBank
                : hitPec ? pecBank
                : EVENT_RESET;
   assign rdData_d = rdReq ? rdSel : rdData_q;

   // Summary vector in mask bit order
   // Each group counts this edge's sets and what survives clears
   // Bits 1 and 7 have no source in this block
   always_comb begin
      irqSummary_d          = SUMMARY_RESET;
      irqSummary_d[MSK_PEC] = |pecBankSet[NUM_CHAN-1:0]
                            | |(pecBank[NUM_CHAN-1:0] & ~pecBankClr[3:0]);
      irqSummary_d[MSK_DIS] = |fltBankSet[7:4]
                            | |(fltBank[7:4] & ~fltBankClr[7:4]);
      irqSummary_d[MSK_DET] = |detBankSet[3:0]
                            | |(detBank[3:0] & ~detBankClr[3:0]);
      irqSummary_d[MSK_CLS] = |detBankSet[7:4]
                            | |(detBank[7:4] & ~detBankClr[7:4]);
      irqSummary_d[MSK_FLT] = |fltBankSet[3:0] | |stlBankSet[7:4]
                            | |(fltBank[3:0] & ~fltBankClr[3:0])
                            | |(stlBank[7:4] & ~stlBankClr[7:4]);
      irqSummary_d[MSK_STR] = |stlBankSet[3:0]
                            | |(stlBank[3:0] & ~stlBankClr[3:0]);
   end

   // Interrupt pin follows masked summary; clearing read drops it
   // Using the next summary releases the pin with the acknowledge
   assign intN_d = ~|(irqSummary_d & irqMask);

   // Re-power of one dual half needs valid discovery and power budget
   assign powerOnGrant_d = powerOnRequest
                         & (~dualCh | (discoveryValid & allocationOk));
   // Shutdown only where overload shutdown is enabled
   assign ovlShut_d = overloadTimeout & ~overloadShutdownOff;

   // Four event registers
   // Detect/class register
   pcel_latch8 uDetBank (
      .clk     (clk),
      .sys_rst (sys_rst),
      .setBits (detBankSet),
      .clrBits (detBankClr),
      .q       (detBank)
   );

   // Disconnect/overload register
   pcel_latch8 uFltBank (
      .clk     (clk),
      .sys_rst (sys_rst),
      .setBits (fltBankSet),
      .clrBits (fltBankClr),
      .q       (fltBank)
   );

   // Start/limit register
   pcel_latch8 uStlBank (
      .clk     (clk),
      .sys_rst (sys_rst),
      .setBits (stlBankSet),
      .clrBits (stlBankClr),
      .q       (stlBank)
   );

   // Power enable change register
   pcel_latch8 uPecBank (
      .clk     (clk),
      .sys_rst (sys_rst),
      .setBits (pecBankSet),
      .clrBits (pecBankClr),
      .q       (pecBank)
   );

   // Partner-wait flags
   // A half that finished first waits here for its partner
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         detPend_q <= '0;
         clsPend_q <= '0;
      end else begin
         detPend_q <= detPend_d;
         clsPend_q <= clsPend_d;
      end
   end

   // Read answer: data, acknowledge, miss flag
   // Unmapped codes answer with a zero byte and a miss
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdData_q <= EVENT_RESET;
         rdAck_q  <= 1'b0;
         rdMiss_q <= 1'b0;
      end else begin
         rdData_q <= rdData_d;
         rdAck_q  <= rdReq;
         rdMiss_q <= rdReq & ~hitAny;
      end
   end

   // Interrupt, summary and channel control outputs
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irqSummary_q   <= SUMMARY_RESET;
         intN_q         <= INT_IDLE;
         powerOnGrant_q <= '0;
         ovlShut_q      <= '0;
      end else begin
         irqSummary_q   <= irqSummary_d;
         intN_q         <= intN_d;
         powerOnGrant_q <= powerOnGrant_d;
         ovlShut_q      <= ovlShut_d;
      end
   end

   // Output drive
   // Every output comes straight from a flip-flop
   assign rdData           = rdData_q;
   assign rdAck            = rdAck_q;
   assign rdMiss           = rdMiss_q;
   assign irqSummary       = irqSummary_q;
   assign int_n            = intN_q;
   assign powerOnGrant     = powerOnGrant_q;
   assign overloadShutdown = ovlShut_q;
endmodule

/* rtl/pcel_pkg.sv */
// Purpose: Constants and types for the channel event latch bank
// Assumes: Four channels, two 4-pair port slots (ch1/2, ch3/4)
// Notes:   Shared by the design and the bench
package pcel_pkg;
   localparam int         NUM_CHAN      = 4;     // Channels per bank
   localparam int         REG_W         = 8;     // Register width
   // Command codes
   localparam logic [7:0] CMD_PWR_EV    = 8'h02; // Power events, plain
   localparam logic [7:0] CMD_PWR_EV_CR = 8'h03; // Power events, clearing
   localparam logic [7:0] CMD_DET_EV    = 8'h04; // Detect/class, plain
   localparam logic [7:0] CMD_DET_EV_CR = 8'h05; // Detect/class, clearing
   localparam logic [7:0] CMD_FLT_EV    = 8'h06; // Disc/overload, plain
   localparam logic [7:0] CMD_FLT_EV_CR = 8'h07; // Disc/overload, clearing
   localparam logic [7:0] CMD_STL_EV    = 8'h08; // Start/limit, plain
   localparam logic [7:0] CMD_STL_EV_CR = 8'h09; // Start/limit, clearing
   // Reset values
   localparam logic [7:0] EVENT_RESET   = 8'h00; // Event registers
   localparam logic [7:0] SUMMARY_RESET = 8'h00; // Summary vector
   localparam logic       INT_IDLE      = 1'b1;  // Interrupt released
   // Field positions
   localparam int         HI_LSB        = 4;     // Upper nibble start
   localparam int         LO_LSB        = 0;     // Lower nibble start
   // Summary / mask bit positions
   localparam int         MSK_PEC       = 0;     // Power enable change
   localparam int         MSK_DIS       = 2;     // Disconnect
   localparam int         MSK_DET       = 3;     // Detection
   localparam int         MSK_CLS       = 4;     // Classification
   localparam int         MSK_FLT       = 5;     // Overload or limit
   localparam int         MSK_STR       = 6;     // Start fault
   // Operating mode; 2'b11 is illegal and acts as manual
   typedef enum logic [1:0] {
      MODE_MANUAL = 2'b00,
      MODE_SEMI   = 2'b01,
      MODE_AUTO   = 2'b10
   } pcel_mode_t;
endpackage

/* testbench/pcel_event_latches_props.sv */
// Purpose: Port-level checks for the channel event latch bank
// Assumes: Bound to every pcel_event_latches instance
// Notes:   Attempts that start in reset are dropped
`timescale 1ns/1ps
module pcel_event_latches_props
   import pcel_pkg::*;
(
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic       rdReq,
   input wire logic [7:0] rdCode,
   input wire logic [7:0] rdData,
   input wire logic       rdAck,
   input wire logic       rdMiss,
   input wire logic [1:0] fourPair,
   input wire logic [1:0] dualSig,
   input wire logic [7:0] irqMask,
   input wire logic [3:0] disconnectSeen,
   input wire logic [3:0] overloadTimeout,
   input wire logic [3:0] overloadShutdownOff,
   input wire logic [3:0] inrushTimeout,
   input wire logic [3:0] discoveryInvalid,
   input wire logic [3:0] powerOnRequest,
   input wire logic [3:0] discoveryValid,
   input wire logic [3:0] allocationOk,
   input wire logic [3:0] powerOnGrant,
   input wire logic [3:0] overloadShutdown,
   input wire logic [7:0] irqSummary,
   input wire logic       int_n
);
   // Channels on a dual-signature 4-pair port
   wire logic [3:0] dualCh = {{2{fourPair[1] & dualSig[1]}},
                              {2{fourPair[0] & dualSig[0]}}};
   // Expected grant and shutdown, one cycle ahead
   wire logic [3:0] grantExp = powerOnRequest &
                               (~dualCh | (discoveryValid & allocationOk));
   wire logic [3:0] shutExp  = overloadTimeout & ~overloadShutdownOff;
   // Codes that have a register behind them
   wire logic       mapped   = rdCode >= CMD_PWR_EV && rdCode <= CMD_STL_EV_CR;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_read_ack: assert property (rdReq |=> rdAck)
      else $error("read not acknowledged next cycle");
   a_ack_cause: assert property (rdAck |-> $past(rdReq))
      else $error("acknowledge without request");
   a_miss_code: assert property (rdReq && !mapped |=>
      rdMiss && rdData == 8'h00)
      else $error("unmapped code not flagged");
   a_hit_code: assert property (rdReq && mapped |=> !rdMiss)
      else $error("mapped code flagged as miss");
   a_data_hold: assert property (!rdReq |=> $stable(rdData))
      else $error("read byte changed without read");
   a_int_level: assert property (1'b1 |=>
      int_n == ~|(irqSummary & $past(irqMask)))
      else $error("interrupt level disagrees with masked summary");
   a_grant_rule: assert property (1'b1 |=>
      powerOnGrant == $past(grantExp))
      else $error("re-power grant wrong");
   a_ovl_shut: assert property (1'b1 |=>
      overloadShutdown == $past(shutExp))
      else $error("overload shutdown wrong");
   a_disc_sum: assert property (|disconnectSeen |=> irqSummary[MSK_DIS])
      else $error("disconnect missing from summary");
   a_start_sum: assert property (|(inrushTimeout & ~discoveryInvalid)
      |=> irqSummary[MSK_STR])
      else $error("start fault missing from summary");

   c_clear_irq: cover property (rdReq && rdCode == CMD_DET_EV_CR && !int_n);
   c_grant: cover property (|powerOnGrant);
   c_miss: cover property (rdMiss);
endmodule

bind pcel_event_latches pcel_event_latches_props u_props (.*);

/* testbench/pcel_host_model.sv */
// Purpose: Host side of the command port, one byte per read
// Assumes: Drives at the falling edge, takes the answer there
// Notes:   Idle code lines show the inverse of the last code
`timescale 1ns/1ps
module pcel_host_model (
   input  wire logic       clk,
   output logic            rdReq,
   output logic [7:0]      rdCode,
   input  wire logic [7:0] rdData,
   input  wire logic       rdAck,
   input  wire logic       rdMiss
);
   initial begin
      rdReq  = 1'b0;
      rdCode = 8'h00;
   end
   // One read; every code, mapped or not, is read the same way
   task automatic rd(input logic [7:0] code, output logic [7:0] data,
                     output logic ack, output logic miss);
      @(negedge clk);
      rdReq  <= 1'b1;
      rdCode <= code;
      @(negedge clk);
      ack    = rdAck;
      data   = rdData;
      miss   = rdMiss;
      rdReq  <= 1'b0;
      rdCode <= ~code;
   endtask
endmodule

/* testbench/testbench.sv */
// Purpose: Self-checking bench for the channel event latch bank
// Assumes: Host model reads; bench drives events at falling edges
// Notes:   Each scenario leaves every bank empty
`timescale 1ns/1ps
module testbench;
   import pcel_pkg::*;
   localparam int DET = 0, DCH = 4, CLS = 8, CCH = 12, DIS = 16;
   localparam int OVL = 20, LIM = 24, INR = 28, PEC = 32, OFF = 36;
   localparam int LIMIT = 3000; // Cycle ceiling
   logic clk = 1'b0, sys_rst = 1'b1;
   logic classChangeOnly = 1'b0, detectChangeOnly = 1'b0;
   logic rdReq, rdAck, rdMiss, int_n, a, m;
   logic [7:0] rdCode, rdData, irqSummary, d, irqMask = '0;
   pcel_mode_t opMode = MODE_SEMI;
   logic [1:0] fourPair = '0, dualSig = '0;
   logic [3:0] powerOnPending = '0, overloadShutdownOff = '0;
   logic [3:0] discoveryInvalid = '0, powerOnRequest = '0;
   logic [3:0] discoveryValid = '0, allocationOk = '0;
   logic [3:0] powerOnGrant, overloadShutdown;
   logic [39:0] evp = '0; // Event pulses, four bits per group
   wire logic [3:0] detectDone = evp[3:0], detectChanged = evp[7:4];
   wire logic [3:0] classDone = evp[11:8], classChanged = evp[15:12];
   wire logic [3:0] disconnectSeen = evp[19:16];
   wire logic [3:0] overloadTimeout = evp[23:20];
   wire logic [3:0] currentHoldTimeout = evp[27:24];
   wire logic [3:0] inrushTimeout = evp[31:28];
   wire logic [3:0] powerEnableChange = evp[35:32], chanOff = evp[39:36];
   int failures = 0, n_compared = 0, cyc = 0;

   always #50 clk = ~clk;

   pcel_event_latches dut (.clk, .sys_rst, .rdReq, .rdCode, .rdData, .rdAck,
      .rdMiss, .opMode, .fourPair, .dualSig, .classChangeOnly,
      .detectChangeOnly, .irqMask, .chanOff, .powerOnPending, .detectDone,
      .detectChanged, .classDone, .classChanged, .disconnectSeen,
      .overloadTimeout, .overloadShutdownOff, .currentHoldTimeout,
      .inrushTimeout, .discoveryInvalid, .powerEnableChange, .powerOnRequest,
      .discoveryValid, .allocationOk, .powerOnGrant, .overloadShutdown,
      .irqSummary, .int_n);
   pcel_host_model host (.clk, .rdReq, .rdCode, .rdData, .rdAck, .rdMiss);

   task automatic print_verdict;
      $display("Compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         failures++;
         print_verdict();
      end
   end

   task automatic chk(input string name, input logic [7:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   function automatic logic [39:0] ev(input int g, input logic [3:0] v);
      return 40'(v) << g;
   endfunction
   // Pulse event lines for one cycle
   task automatic pulse(input logic [39:0] v);
      @(negedge clk);
      evp = v;
      @(negedge clk);
      evp = '0;
   endtask
   // Read one code and compare the byte
   task automatic rdc(input logic [7:0] code, exp);
      host.rd(code, d, a, m);
      chk("rdAck", {7'h0, a}, 8'h01);
      chk("rdData", d, exp);
   endtask

   task automatic t_reset;
      for (int c = 2; c < 10; c++)
         rdc(8'(c), EVENT_RESET);
      chk("int_n", {7'h0, int_n}, {7'h0, INT_IDLE});
      rdc(8'h0c, 8'h00);
      chk("rdMiss", {7'h0, m}, 8'h01);
   endtask
   task automatic t_detect;
      irqMask = 8'h08;
      pulse(ev(DET, 4'h4) | ev(CLS, 4'h8));
      chk("int_n", {7'h0, int_n}, 8'h00);
      chk("irqSummary", irqSummary, 8'h18);
      rdc(CMD_DET_EV, 8'h84);
      rdc(CMD_DET_EV_CR, 8'h84);
      chk("int_n", {7'h0, int_n}, 8'h01);
      chk("irqSummary", irqSummary, 8'h00);
      rdc(CMD_DET_EV, 8'h00);
      pulse(ev(CLS, 4'h1));
      chk("int_n", {7'h0, int_n}, 8'h01);
      rdc(CMD_DET_EV_CR, 8'h10);
      irqMask = 8'h00;
      {classChangeOnly, detectChangeOnly} = 2'b11;
      pulse(ev(DET, 4'h3) | ev(DCH, 4'h2) | ev(CLS, 4'h3) | ev(CCH, 4'h1));
      rdc(CMD_DET_EV_CR, 8'h12);
      {classChangeOnly, detectChangeOnly} = 2'b00;
   endtask
   task automatic t_fault_start;
      overloadShutdownOff = 4'h4;
      pulse(ev(DIS, 4'h2) | ev(OVL, 4'h6));
      chk("shutdown", {4'h0, overloadShutdown}, 8'h02);
      rdc(CMD_FLT_EV_CR, 8'h26);
      rdc(CMD_FLT_EV, 8'h00);
      overloadShutdownOff = 4'h0;
      pulse(ev(LIM, 4'h8) | ev(INR, 4'h1) | ev(PEC, 4'h1));
      rdc(CMD_STL_EV, 8'h81);
      rdc(CMD_PWR_EV_CR, 8'h01);
      rdc(CMD_STL_EV_CR, 8'h81);
      opMode = MODE_AUTO;
      discoveryInvalid = 4'h2;
      pulse(ev(INR, 4'h3));
      rdc(CMD_STL_EV_CR, 8'h01);
      discoveryInvalid = 4'h0;
   endtask
   task automatic t_four_pair;
      opMode = MODE_SEMI;
      fourPair = 2'b01;
      pulse(ev(DET, 4'h1));
      rdc(CMD_DET_EV, 8'h00);
      pulse(ev(DET, 4'h2));
      rdc(CMD_DET_EV_CR, 8'h03);
      pulse(ev(CLS, 4'h1));
      rdc(CMD_DET_EV_CR, 8'h10);
      pulse(ev(DIS, 4'h1));
      rdc(CMD_FLT_EV_CR, 8'h30);
      pulse(ev(OVL, 4'h2) | ev(LIM, 4'h1));
      rdc(CMD_FLT_EV_CR, 8'h02);
      rdc(CMD_STL_EV_CR, 8'h10);
      powerOnPending = 4'h3;
      pulse(ev(DET, 4'h1));
      rdc(CMD_DET_EV_CR, 8'h01);
      powerOnPending = 4'h0;
   endtask
   task automatic t_dual;
      dualSig = 2'b01;
      pulse(ev(DIS, 4'h1));
      rdc(CMD_FLT_EV_CR, 8'h10);
      pulse(ev(CLS, 4'h1));
      rdc(CMD_DET_EV, 8'h00);
      pulse(ev(CLS, 4'h2));
      rdc(CMD_DET_EV_CR, 8'h30);
      opMode = MODE_MANUAL;
      pulse(ev(CLS, 4'h1));
      rdc(CMD_DET_EV_CR, 8'h10);
      opMode = MODE_AUTO;
      pulse(ev(DET, 4'h1));
      rdc(CMD_DET_EV_CR, 8'h01);
      discoveryValid = 4'h1;
      powerOnRequest = 4'h1;
      @(negedge clk);
      chk("grant", {4'h0, powerOnGrant}, 8'h00);
      allocationOk = 4'h1;
      @(negedge clk);
      chk("grant", {4'h0, powerOnGrant}, 8'h01);
      powerOnRequest = 4'h0;
      {fourPair, dualSig, opMode} = {4'h0, MODE_SEMI};
   endtask
   task automatic t_off_race;
      pulse(ev(DET, 4'h3) | ev(DIS, 4'h1) | ev(OVL, 4'h2) | ev(LIM, 4'h3));
      pulse(ev(OFF, 4'h1));
      rdc(CMD_DET_EV_CR, 8'h02);
      rdc(CMD_FLT_EV_CR, 8'h02);
      rdc(CMD_STL_EV_CR, 8'h20);
      fork
         rdc(CMD_DET_EV_CR, 8'h00);
         pulse(ev(DET, 4'h4));
      join
      rdc(CMD_DET_EV_CR, 8'h04);
   endtask

   initial begin
      repeat (4) @(negedge clk);
      sys_rst = 1'b0;
      t_reset();
      t_detect();
      t_fault_start();
      t_four_pair();
      t_dual();
      t_off_race();
      print_verdict();
   end
endmodule
